/* include/cdsx_pkg.sv */
// package for the complement / decrement-skip execution block
// assumes a core with a four-phase instruction cycle
package cdsx_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
    localparam logic DEST_ACC = 1'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        CDSX_Q1 = 2'b00,
        CDSX_Q2 = 2'b01,
        CDSX_Q3 = 2'b10,
        CDSX_Q4 = 2'b11
    } cdsx_phase_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
        logic toFile;
        logic toAcc;
        logic zeroWr;
        logic zeroVal;
    } cdsx_result_t;
endpackage

/* verilog/cdsx_exec.sv */
// execution of complement and decrement-skip on a four-phase cycle
// assumes register file answers fileRdData combinationally to fileRdAddr
// Notes on behaviour
// - complement inverts the addressed register and sets zero from result.
// - complement goes to the accumulator when dest is 0, else the register.
// - complement is one cycle: decode, read, process, write in Q1..Q4.
// - decrement-skip subtracts one and leaves every status flag alone.
// - decrement-skip goes to the accumulator when dest is 0, else register.
// - a zero decrement result turns the next cycle into an idle no-op.
// - a nonzero decrement result lets the next instruction run normally.
`timescale 1ns/10ps
`default_nettype none
module cdsx_exec (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [cdsx_pkg::INSTR_W-1:0] instrWord,
    input wire logic [cdsx_pkg::DATA_W-1:0] fileRdData,
    output logic [cdsx_pkg::ADDR_W-1:0] fileRdAddr,
    output cdsx_pkg::cdsx_result_t result,
    output logic skipNext,
    output cdsx_pkg::cdsx_phase_t phase
);
    import cdsx_pkg::*;

    // ==========================================================
    // state
    cdsx_phase_t phase_r, phase_nxt;
    logic [INSTR_W-1:0] ir_r, ir_nxt;
    logic [DATA_W-1:0] opnd_r, opnd_nxt;
    logic [DATA_W-1:0] res_r, res_nxt;
    logic nop_r, nop_nxt;
    logic skip_r, skip_nxt;
    cdsx_result_t out_r, out_nxt;
    logic isComp, isDec, destFile;

    // ==========================================================
    // helpers
    function automatic logic [5:0] opcode_of(
        input logic [INSTR_W-1:0] word
    );
        return word[INSTR_W-1:OPC_LSB];
    endfunction

    function automatic logic is_zero(input logic [DATA_W-1:0] value);
        return value == DATA_RESET;
    endfunction

    // ==========================================================
    // decode
    // field decode
    assign isComp = opcode_of(ir_r) == OPC_COMPLEMENT;
    assign isDec = opcode_of(ir_r) == OPC_DEC_SKIP;
    assign destFile = ir_r[DEST_BIT] != DEST_ACC;
    assign fileRdAddr = ir_r[ADDR_W-1:0];

    always_comb begin
        phase_nxt = phase_r;
        ir_nxt = ir_r;
        opnd_nxt = opnd_r;
        res_nxt = res_r;
        nop_nxt = nop_r;
        skip_nxt = 1'b0;
        out_nxt = '0;
        if (clkEn) begin
            case (phase_r)
                CDSX_Q1: begin
                    phase_nxt = CDSX_Q2;
                    ir_nxt = instrWord;
                end
                CDSX_Q2: begin
                    phase_nxt = CDSX_Q3;
                    if (!nop_r) begin
                        opnd_nxt = fileRdData;
                    end
                end
                CDSX_Q3: begin
                    phase_nxt = CDSX_Q4;
                    if (isComp) begin
                        res_nxt = ~opnd_r;
                    end else begin
                        res_nxt = opnd_r - 8'h01;
                    end
                end
                CDSX_Q4: begin
                    phase_nxt = CDSX_Q1;
                    nop_nxt = 1'b0;
                    if (!nop_r && (isComp || isDec)) begin
                        out_nxt.data = res_r;
                        out_nxt.addr = ir_r[ADDR_W-1:0];
                        out_nxt.toFile = destFile;
                        out_nxt.toAcc = !destFile;
                        out_nxt.zeroWr = isComp;
                        out_nxt.zeroVal = isComp && is_zero(res_r);
                        if (isDec && is_zero(res_r)) begin
                            nop_nxt = 1'b1;
                            skip_nxt = 1'b1;
                        end
                    end
                end
                default: phase_nxt = CDSX_Q1;
            endcase
        end else begin
            out_nxt = out_r;
            skip_nxt = skip_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            phase_r <= CDSX_Q1;
            ir_r <= '0;
            opnd_r <= DATA_RESET;
            res_r <= DATA_RESET;
            nop_r <= 1'b0;
            skip_r <= 1'b0;
            out_r <= '0;
        end else begin
            phase_r <= phase_nxt;
            ir_r <= ir_nxt;
            opnd_r <= opnd_nxt;
            res_r <= res_nxt;
            nop_r <= nop_nxt;
            skip_r <= skip_nxt;
            out_r <= out_nxt;
        end
    end

    assign result = out_r;
    assign skipNext = skip_r;
    assign phase = phase_r;

    // ==========================================================
    // checks
    // complement result
    a_comp_value: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !nop_r && isComp
        |=> out_r.data == ~$past(opnd_r, 2) && out_r.zeroWr)
        else $error("complement result wrong");

    a_comp_zero: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !nop_r && isComp
        |=> out_r.zeroVal == (~$past(opnd_r) == DATA_RESET))
        else $error("complement zero flag wrong");

    a_comp_dest: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !nop_r && isComp
        |=> out_r.toFile == destFile && out_r.toAcc != destFile)
        else $error("complement destination wrong");

    a_phase_order: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 |=> phase_r == CDSX_Q1)
        else $error("phase did not wrap");

    a_phase_step: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r != CDSX_Q4
        |=> phase_r == $past(phase_r) + 2'd1)
        else $error("phase skipped a step");

    a_freeze_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !clkEn
        |=> $stable(phase_r) && $stable(out_r) && $stable(skip_r))
        else $error("state moved with enable low");

    a_dec_flags: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !nop_r && isDec
        |=> !out_r.zeroWr && out_r.data == $past(opnd_r, 2) - 8'h01)
        else $error("decrement touched flags or value");

    a_dec_dest: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !nop_r && isDec
        |=> out_r.toFile == destFile)
        else $error("decrement destination wrong");

    a_dec_skip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !nop_r && isDec && is_zero(res_r)
        |=> skipNext && nop_r)
        else $error("zero decrement did not skip");

    a_skip_idle: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && nop_r
        |=> !out_r.toAcc && !out_r.toFile && !skip_r)
        else $error("skip cycle not idle");

    a_skip_slot: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        skip_r |-> nop_r && phase_r == CDSX_Q1)
        else $error("skip pulse without idle slot");

    a_skip_pulse: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        skip_r && clkEn |=> !skip_r)
        else $error("skip pulse too long");

    a_no_skip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && isDec && res_r != DATA_RESET
        |=> !skip_r && !nop_r)
        else $error("skip on nonzero result");

    a_addr_field: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q1
        |=> fileRdAddr == $past(instrWord[ADDR_W-1:0]))
        else $error("address field wrong");

    a_other_quiet: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clkEn && phase_r == CDSX_Q4 && !isComp && !isDec
        |=> !out_r.toAcc && !out_r.toFile && !skip_r)
        else $error("strobe on other opcode");
endmodule // cdsx_exec
`default_nettype wire

/* testbench/tb_complement_and_decrement_skip_exec.sv */
// bench for the complement / decrement-skip execution block
// assumes cdsx_pkg and cdsx_exec are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_complement_and_decrement_skip_exec;
import cdsx_pkg::*;
logic sys_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, expSkip = 1'b0;
logic [INSTR_W-1:0] instrWord = '0;
logic [DATA_W-1:0] fileRdData = '0;
logic [ADDR_W-1:0] fileRdAddr;
logic skipNext;
cdsx_phase_t phase;
cdsx_result_t result, expR = '0;
int bad_count = 0, comparisons = 0;
logic [31:0] seed = 32'hf57087af;
cdsx_exec cdsx_exec_i (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
    .instrWord(instrWord), .fileRdData(fileRdData),
    .fileRdAddr(fileRdAddr), .result(result), .skipNext(skipNext),
    .phase(phase));
always #50 sys_clk = ~sys_clk;
// ==========================
// helpers
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
        bad_count++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function automatic cdsx_result_t predict(input logic [13:0] w,
    input logic [7:0] d);
    cdsx_result_t r;
    logic cmp;
    r = '0;
    cmp = w[13:8] == 6'h09;
    if (cmp || w[13:8] == 6'h0b) begin
        r.data = cmp ? ~d : d - 8'h01;
        r.addr = w[6:0];
        r.toFile = w[7];
        r.toAcc = !w[7];
        r.zeroWr = cmp;
        r.zeroVal = cmp && r.data == 8'h00;
    end
    return r;
endfunction
// one instruction; checks the one before it on entry
task automatic exec(input logic [5:0] op, input logic d,
    input logic [6:0] a, input logic [7:0] v, input logic st);
    instrWord <= {op, d, a};
    fileRdData <= v;
    #1;
    check(result, expR);
    check(result.zeroVal, expR.zeroVal);
    check(skipNext, expSkip);
    expR = expSkip ? '0 : predict({op, d, a}, v);
    expSkip = !expSkip && op == OPC_DEC_SKIP && v == 8'h01;
    @(posedge sys_clk);
    // stall over the read phase with wrong data on the bus
    if (st) begin
        clkEn <= 1'b0;
        fileRdData <= ~v;
    end
    #1;
    if (expR.toFile | expR.toAcc) check(fileRdAddr, a);
    check(phase, CDSX_Q2);
    if (st) begin
        @(posedge sys_clk);
        clkEn <= 1'b1;
        fileRdData <= v;
        #1;
        check(phase, CDSX_Q2);
    end
    repeat (3) @(posedge sys_clk);
endtask
// enable low between instructions: nothing may move
task automatic hold(input int n);
    clkEn <= 1'b0;
    repeat (n) begin
        #1;
        check(result, expR);
        check(skipNext, expSkip);
        check(phase, CDSX_Q1);
        @(posedge sys_clk);
    end
    clkEn <= 1'b1;
endtask
// reset in mid-run, on top of a pending skip
task automatic reinit();
    resetn <= 1'b0;
    #1;
    check(result, expR);
    check(skipNext, expSkip);
    repeat (2) @(posedge sys_clk);
    #1;
    check(result, '0);
    check(skipNext, 1'b0);
    check(phase, CDSX_Q1);
    @(posedge sys_clk);
    resetn <= 1'b1;
    expR = '0;
    expSkip = 1'b0;
endtask
task automatic conclude();
    if (bad_count == 0 && comparisons > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
// ==========================
// main sequence
initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    exec(OPC_COMPLEMENT, 1'b0, 7'h00, 8'hff, 1'b0);
    exec(OPC_COMPLEMENT, 1'b1, 7'h7f, 8'h13, 1'b1);
    exec(OPC_DEC_SKIP, 1'b1, 7'h7f, 8'h01, 1'b0);
    hold(2);
    exec(OPC_DEC_SKIP, 1'b0, 7'h05, 8'h01, 1'b0);
    exec(OPC_DEC_SKIP, 1'b0, 7'h05, 8'h00, 1'b1);
    exec(OPC_DEC_SKIP, 1'b1, 7'h06, 8'h02, 1'b0);
    exec(6'h0a, 1'b1, 7'h11, 8'h01, 1'b0);
    exec(OPC_DEC_SKIP, 1'b0, 7'h22, 8'h01, 1'b0);
    reinit();
    exec(OPC_DEC_SKIP, 1'b1, 7'h23, 8'h02, 1'b0);
    for (int i = 0; i < 300; i++) begin
        seed = lfsr(seed);
        exec(seed[3] ? (seed[2] ? OPC_COMPLEMENT : OPC_DEC_SKIP)
            : seed[13:8], seed[7], seed[20:14],
            seed[4] ? 8'h01 : seed[31:24], seed[5] & seed[11]);
        if (seed[6] && seed[12]) hold(int'(seed[23:22]) + 2);
    end
    exec(6'h00, 1'b0, 7'h00, 8'h00, 1'b0);
    conclude();
end
endmodule // tb_complement_and_decrement_skip_exec
`default_nettype wire
